// File: core/rsc_reset_source_controller.sv
// Purpose: merges all reset requests into one system reset and records its cause
// Assumes: analog monitors, comparator and pin arrive asynchronously; watchdog on CLK_I
// Notes: flash array is modelled inside; timing of writes and erases is self-contained
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module rsc_reset_source_controller #(
	parameter int MCD_TIMEOUT_CYCLES = rsc_pkg::MCD_TIMEOUT_CYCLES,
	parameter int FLASH_BYTES = 1024,
	parameter int PAGE_BYTES = 512,
	parameter logic [15:0] LOCK_ADDR = 16'h03FF
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [31:0] HRDATA_O,
	input wire logic RST_PIN_I,
	output logic RST_PIN_O,
	output logic RST_PIN_OE_O,
	input wire logic SUPPLY_ABOVE_LOW_I,
	input wire logic SUPPLY_ABOVE_HIGH_I,
	input wire logic LEVEL_MON_LOW_I,
	input wire logic COMP_PLUS_ABOVE_I,
	input wire logic MON_CLK_I,
	input wire logic WDT_TIMEOUT_I,
	output logic WDT_TICK_O,
	input wire logic FLASH_REQ_I,
	input wire logic FLASH_ERASE_I,
	input wire logic [15:0] FLASH_ADDR_I,
	input wire logic [7:0] FLASH_WDATA_I,
	input wire logic FLASH_RD_I,
	input wire logic [15:0] FLASH_RADDR_I,
	input wire logic FLASH_SECURE_I,
	output logic [7:0] FLASH_RDATA_O,
	output logic CPU_STALL_O,
	output logic SYS_RST_N_O
);
	localparam int FA_W = $clog2(FLASH_BYTES);
	localparam int PG_W = $clog2(PAGE_BYTES);
	localparam int MCD_W = $clog2(MCD_TIMEOUT_CYCLES + 1);
	localparam int HOLD_W = $clog2(rsc_pkg::POR_DELAY_CYCLES + 1);
	localparam int FL_W = $clog2(rsc_pkg::FLASH_ERASE_CYCLES + 1);
	localparam int WD_W = $clog2(rsc_pkg::WDT_DIV);

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	// two-flop synchronisers for everything coming from pins or analog
	logic [rsc_pkg::SY_N-1:0] async_in;
	logic [rsc_pkg::SY_N-1:0] meta_q;
	logic [rsc_pkg::SY_N-1:0] sync_q;
	assign async_in = {MON_CLK_I, COMP_PLUS_ABOVE_I, LEVEL_MON_LOW_I,
		SUPPLY_ABOVE_HIGH_I, SUPPLY_ABOVE_LOW_I, RST_PIN_I};
	generate
		for (genvar g = 0; g < rsc_pkg::SY_N; g++) begin : g_sync
			always_ff @(posedge CLK_I) begin
				if (!RST_N_I) begin
					meta_q[g] <= 1'b1;
					sync_q[g] <= 1'b1;
				end else begin
					meta_q[g] <= async_in[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	rsc_pkg::rsc_state_type state_q;
	rsc_pkg::rsc_cause_type cause_q;
	rsc_pkg::rsc_cause_type cause_new;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic sys_rst_n_q;
	logic pin_drive_q;
	logic [1:0] pin_mask_q;
	logic mon_on_q;
	logic mon_sel_q;
	logic thr_q;
	logic lvl_q;
	logic comp_en_q;
	logic mcd_en_q;
	logic [6:0] flags_q;
	logic [6:0] flags_d;

	// bus slave
	logic ap;
	logic dp_wr_q;
	logic rd_pend_q;
	logic [31:0] dp_addr_q;
	logic [31:0] hrdata_q;
	logic wr_cause;
	logic wr_mon;
	logic [7:0] cause_rd;
	logic [7:0] mon_rd;
	logic [7:0] rd_byte;
	logic running;
	logic supply_above;

	assign running = (state_q == rsc_pkg::ST_RUN);
	assign ap = HSEL_I && HTRANS_I[1] && HREADY_I;
	assign wr_cause = dp_wr_q && running && (dp_addr_q == rsc_pkg::ADDR_CAUSE);
	assign wr_mon = dp_wr_q && running && (dp_addr_q == rsc_pkg::ADDR_MON);
	assign supply_above = thr_q ? sync_q[rsc_pkg::SY_ABV_HI] : sync_q[rsc_pkg::SY_ABV_LO];
	assign cause_rd = {1'b1, flags_q};
	assign mon_rd = {mon_on_q, supply_above, thr_q, lvl_q, 4'h0};
	assign rd_byte = (dp_addr_q == rsc_pkg::ADDR_CAUSE) ? cause_rd :
		(dp_addr_q == rsc_pkg::ADDR_MON) ? mon_rd : 8'h00;

	// reads take one wait state so data come from a flop after any prior write
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			dp_wr_q <= 1'b0;
			rd_pend_q <= 1'b0;
			dp_addr_q <= 32'h0000_0000;
			hrdata_q <= 32'h0000_0000;
		end else begin
			dp_wr_q <= ap && HWRITE_I && (HSIZE_I == rsc_pkg::HSIZE_WORD);
			rd_pend_q <= ap && !HWRITE_I;
			if (ap) begin
				dp_addr_q <= HADDR_I;
			end
			if (rd_pend_q) begin
				hrdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end
	assign HREADYOUT_O = !rd_pend_q;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = hrdata_q;

	// missing clock detector watching the monitored clock MON_CLK_I seen through the synchroniser
	logic mclk_prev_q;
	logic [MCD_W-1:0] mcd_cnt_q;
	logic req_mcd;
	assign req_mcd = mcd_en_q && (mcd_cnt_q == MCD_W'(MCD_TIMEOUT_CYCLES));
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			mclk_prev_q <= 1'b1;
			mcd_cnt_q <= '0;
		end else begin
			mclk_prev_q <= sync_q[rsc_pkg::SY_MCLK];
			if (!mcd_en_q || (sync_q[rsc_pkg::SY_MCLK] != mclk_prev_q)) begin
				mcd_cnt_q <= '0;
			end else if (!req_mcd) begin
				mcd_cnt_q <= mcd_cnt_q + 1'b1;
			end
		end
	end

	// flash: self-timed, stalls the core while busy
	logic fl_busy_q;
	logic fl_erase_q;
	logic [FL_W-1:0] fl_cnt_q;
	logic [FA_W-1:0] fl_addr_q;
	logic [7:0] fl_data_q;
	logic [FL_W-1:0] fl_len;
	logic fl_done;
	logic fl_wr_err;
	logic fl_rd_err;
	logic fl_start;
	logic [7:0] fl_mem [FLASH_BYTES];
	logic [7:0] fl_rdata_q;

	assign fl_wr_err = (FLASH_ADDR_I > LOCK_ADDR) || FLASH_SECURE_I || !(mon_on_q && thr_q);
	assign fl_rd_err = FLASH_RD_I && ((FLASH_RADDR_I > LOCK_ADDR) || FLASH_SECURE_I);
	assign fl_start = FLASH_REQ_I && running && !fl_busy_q && !fl_wr_err;
	assign fl_len = fl_erase_q ? FL_W'(rsc_pkg::FLASH_ERASE_CYCLES) :
		FL_W'(rsc_pkg::FLASH_WRITE_CYCLES);
	assign fl_done = fl_busy_q && (fl_cnt_q == fl_len);
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			fl_busy_q <= 1'b0;
			fl_erase_q <= 1'b0;
			fl_cnt_q <= '0;
			fl_addr_q <= '0;
			fl_data_q <= 8'h00;
		end else if (fl_start) begin
			fl_busy_q <= 1'b1;
			fl_erase_q <= FLASH_ERASE_I;
			fl_cnt_q <= FL_W'(1);
			fl_addr_q <= FLASH_ADDR_I[FA_W-1:0];
			fl_data_q <= FLASH_WDATA_I;
		end else if (fl_done) begin
			fl_busy_q <= 1'b0;
		end else if (fl_busy_q) begin
			fl_cnt_q <= fl_cnt_q + 1'b1;
		end
	end
	// non-volatile contents: deliberately not reset
	always_ff @(posedge CLK_I) begin
		if (fl_done) begin
			for (int i = 0; i < FLASH_BYTES; i++) begin
				if (fl_erase_q && ((FA_W'(i) >> PG_W) == (fl_addr_q >> PG_W))) begin
					fl_mem[i] <= rsc_pkg::FLASH_ERASED;
				end
			end
			if (!fl_erase_q) begin
				fl_mem[fl_addr_q] <= fl_mem[fl_addr_q] & fl_data_q;
			end
		end
		fl_rdata_q <= fl_mem[FLASH_RADDR_I[FA_W-1:0]];
	end
	assign FLASH_RDATA_O = fl_rdata_q;
	assign CPU_STALL_O = fl_busy_q;

	// reset requests
	logic req_mon;
	logic req_pin;
	logic req_comp;
	logic req_sw;
	logic req_flash;
	logic lvl_req;
	logic any_req;
	logic hold_done;
	logic exit_hold;
	assign req_mon = (lvl_q && !sync_q[rsc_pkg::SY_LVL_LOW]) == 1'b0 && lvl_q
		|| (mon_on_q && mon_sel_q && !supply_above);
	// own drive on the pin is masked until it has left the synchroniser
	assign req_pin = !sync_q[rsc_pkg::SY_PIN] && !pin_drive_q && (pin_mask_q == 2'b00);
	assign req_comp = comp_en_q && !sync_q[rsc_pkg::SY_CMP_ABV];
	assign req_sw = wr_cause && HWDATA_I[rsc_pkg::B_SW];
	assign req_flash = (FLASH_REQ_I && running && !fl_busy_q && fl_wr_err) || fl_rd_err;
	assign lvl_req = req_mon || req_pin || req_comp;
	assign any_req = lvl_req || req_mcd || WDT_TIMEOUT_I || req_flash || req_sw;
	assign hold_done = (cause_q == rsc_pkg::CAUSE_POR) ?
		(hold_cnt_q >= HOLD_W'(rsc_pkg::POR_DELAY_CYCLES)) :
		(hold_cnt_q >= HOLD_W'(rsc_pkg::RESET_HOLD_CYCLES));
	assign exit_hold = !running && hold_done && !lvl_req;

	always_comb begin
		cause_new = rsc_pkg::CAUSE_NONE;
		if (req_sw) cause_new = rsc_pkg::CAUSE_SW;
		if (req_flash) cause_new = rsc_pkg::CAUSE_FLASH;
		if (WDT_TIMEOUT_I) cause_new = rsc_pkg::CAUSE_WDT;
		if (req_comp) cause_new = rsc_pkg::CAUSE_COMP;
		if (req_mcd) cause_new = rsc_pkg::CAUSE_MCD;
		if (req_pin) cause_new = rsc_pkg::CAUSE_PIN;
		if (req_mon) cause_new = rsc_pkg::CAUSE_MON;
	end

	always_comb begin
		flags_d = 7'h00;
		unique case (cause_q)
			rsc_pkg::CAUSE_POR, rsc_pkg::CAUSE_MON: flags_d[rsc_pkg::B_POR] = 1'b1;
			rsc_pkg::CAUSE_PIN: flags_d[rsc_pkg::B_PIN] = 1'b1;
			rsc_pkg::CAUSE_MCD: flags_d[rsc_pkg::B_MCD] = 1'b1;
			rsc_pkg::CAUSE_COMP: flags_d[rsc_pkg::B_COMP] = 1'b1;
			rsc_pkg::CAUSE_WDT: flags_d[rsc_pkg::B_WDT] = 1'b1;
			rsc_pkg::CAUSE_FLASH: flags_d[rsc_pkg::B_FERR] = 1'b1;
			rsc_pkg::CAUSE_SW: flags_d[rsc_pkg::B_SW] = 1'b1;
			rsc_pkg::CAUSE_NONE: flags_d = 7'h00;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state_q <= rsc_pkg::ST_HOLD;
			cause_q <= rsc_pkg::CAUSE_POR;
			hold_cnt_q <= '0;
			sys_rst_n_q <= 1'b0;
			pin_drive_q <= 1'b1;
		end else if (running && any_req) begin
			state_q <= rsc_pkg::ST_HOLD;
			cause_q <= cause_new;
			hold_cnt_q <= '0;
			sys_rst_n_q <= 1'b0;
			pin_drive_q <= req_mon;
		end else if (exit_hold) begin
			state_q <= rsc_pkg::ST_RUN;
			sys_rst_n_q <= 1'b1;
			pin_drive_q <= 1'b0;
		end else if (!running) begin
			if (!hold_done) begin
				hold_cnt_q <= hold_cnt_q + 1'b1;
			end
			if (req_mon && cause_q != rsc_pkg::CAUSE_POR) begin
				cause_q <= rsc_pkg::CAUSE_MON;
				pin_drive_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pin_mask_q <= 2'b11;
		end else begin
			pin_mask_q <= {pin_mask_q[0], pin_drive_q};
		end
	end
	assign RST_PIN_O = 1'b0;
	assign RST_PIN_OE_O = pin_drive_q;
	assign SYS_RST_N_O = sys_rst_n_q;

	// enables and flags; flags change only when a reset ends
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			mon_on_q <= rsc_pkg::RST_MON_ON;
			mon_sel_q <= rsc_pkg::RST_MON_SEL;
			thr_q <= rsc_pkg::RST_THR;
			lvl_q <= rsc_pkg::RST_LVL;
			comp_en_q <= 1'b0;
			mcd_en_q <= 1'b0;
			flags_q <= rsc_pkg::RST_FLAGS;
		end else if (exit_hold) begin
			flags_q <= flags_d;
			comp_en_q <= 1'b0;
			mcd_en_q <= 1'b0;
			thr_q <= rsc_pkg::RST_THR;
			lvl_q <= rsc_pkg::RST_LVL;
			if (cause_q == rsc_pkg::CAUSE_POR) begin
				mon_on_q <= rsc_pkg::RST_MON_ON;
				mon_sel_q <= rsc_pkg::RST_MON_SEL;
			end
		end else if (wr_cause) begin
			mon_sel_q <= HWDATA_I[rsc_pkg::B_POR];
			mcd_en_q <= HWDATA_I[rsc_pkg::B_MCD];
			comp_en_q <= HWDATA_I[rsc_pkg::B_COMP];
		end else if (wr_mon) begin
			mon_on_q <= HWDATA_I[rsc_pkg::B_MON_ON];
			thr_q <= HWDATA_I[rsc_pkg::B_THR];
			lvl_q <= HWDATA_I[rsc_pkg::B_LVL];
		end
	end

	// watchdog prescaler restarts with every reset
	logic [WD_W-1:0] wdt_div_q;
	logic wdt_tick_q;
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || !running) begin
			wdt_div_q <= '0;
			wdt_tick_q <= 1'b0;
		end else begin
			wdt_tick_q <= (wdt_div_q == WD_W'(rsc_pkg::WDT_DIV - 1));
			wdt_div_q <= (wdt_div_q == WD_W'(rsc_pkg::WDT_DIV - 1)) ? '0 : wdt_div_q + 1'b1;
		end
	end
	assign WDT_TICK_O = wdt_tick_q;

	chk_pin_flag_set: assert property (
		(exit_hold && cause_q == rsc_pkg::CAUSE_PIN) |=> flags_q == 7'h01 && SYS_RST_N_O)
		else $error("pin cause not recorded");
	chk_por_others_clear: assert property (
		flags_q[rsc_pkg::B_POR] |-> (flags_q & ~7'h02) == 7'h00)
		else $error("other flags set with power flag");
	chk_one_cause: assert property ($onehot0(flags_q))
		else $error("more than one cause flag");
	chk_sw_force: assert property ((req_sw && running) |=> !SYS_RST_N_O ##1 !SYS_RST_N_O)
		else $error("software reset not forced");
	chk_pin_undriven: assert property (
		RST_PIN_OE_O |-> (cause_q == rsc_pkg::CAUSE_POR || cause_q == rsc_pkg::CAUSE_MON))
		else $error("pin driven for a non-power cause");
	chk_mcd_timeout: assert property (
		(running && mcd_en_q && mcd_cnt_q == MCD_W'(MCD_TIMEOUT_CYCLES)) |=> !SYS_RST_N_O)
		else $error("missing clock reset absent");
	chk_flash_guard: assert property (
		(running && FLASH_REQ_I && !fl_busy_q && !(mon_on_q && thr_q)) |=> !SYS_RST_N_O && !fl_busy_q)
		else $error("flash op without high monitor");
	chk_stall_bound: assert property (
		fl_start |=> CPU_STALL_O [*8] ##[1:400] !CPU_STALL_O)
		else $error("flash stall length wrong");
	chk_bit7_read: assert property (
		(rd_pend_q && dp_addr_q == rsc_pkg::ADDR_CAUSE) |=> HRDATA_O[7] && HREADYOUT_O)
		else $error("top cause bit not one");
	chk_mon_preserve: assert property (
		(exit_hold && cause_q != rsc_pkg::CAUSE_POR) |=> mon_on_q == $past(mon_on_q))
		else $error("monitor enable not preserved");
	chk_erase_value: assert property (
		(fl_done && fl_erase_q) |=> fl_mem[$past(fl_addr_q)] == rsc_pkg::FLASH_ERASED)
		else $error("erase did not give all ones");
endmodule

// File: core/rsc_pkg.sv
// Purpose: shared constants and types of the reset source controller
// Assumes: 200 MHz system clock, AHB-Lite register access, 32-bit word per register
// Notes: register indices are scaled by four to form byte addresses
package rsc_pkg;
	localparam logic [7:0] IDX_CAUSE = 8'hEF;
	localparam logic [7:0] IDX_MON = 8'hFF;
	localparam logic [31:0] ADDR_CAUSE = {22'h00_0000, IDX_CAUSE, 2'b00};
	localparam logic [31:0] ADDR_MON = {22'h00_0000, IDX_MON, 2'b00};
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// reset_cause_register fields
	localparam int B_PIN = 0;
	localparam int B_POR = 1;
	localparam int B_MCD = 2;
	localparam int B_WDT = 3;
	localparam int B_SW = 4;
	localparam int B_COMP = 5;
	localparam int B_FERR = 6;
	localparam int B_FIXED = 7;

	// monitor_control_register fields
	localparam int B_MON_ON = 7;
	localparam int B_STAT = 6;
	localparam int B_THR = 5;
	localparam int B_LVL = 4;

	// values after reset
	localparam logic RST_MON_ON = 1'b1;
	localparam logic RST_MON_SEL = 1'b1;
	localparam logic RST_THR = 1'b0;
	localparam logic RST_LVL = 1'b1;
	localparam logic [6:0] RST_FLAGS = 7'h00;

	// positions in the synchroniser vector
	localparam int SY_PIN = 0;
	localparam int SY_ABV_LO = 1;
	localparam int SY_ABV_HI = 2;
	localparam int SY_LVL_LOW = 3;
	localparam int SY_CMP_ABV = 4;
	localparam int SY_MCLK = 5;
	localparam int SY_N = 6;

	// timing
	localparam int CLK_MHZ = 200;
	localparam int MCD_TIMEOUT_US = 100;
	localparam int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
	localparam int WDT_DIV = 12;
	localparam int RESET_HOLD_CYCLES = 16;
	localparam int POR_DELAY_CYCLES = 64;
	localparam int FLASH_WRITE_CYCLES = 40;
	localparam int FLASH_ERASE_CYCLES = 400;
	localparam logic [7:0] FLASH_ERASED = 8'hFF;

	typedef enum logic [1:0] {ST_RUN, ST_HOLD} rsc_state_type;
	typedef enum logic [3:0] {
		CAUSE_NONE, CAUSE_POR, CAUSE_MON, CAUSE_PIN, CAUSE_MCD,
		CAUSE_COMP, CAUSE_WDT, CAUSE_FLASH, CAUSE_SW
	} rsc_cause_type;
endpackage

// File: tb/rsc_source_model.sv
// Purpose: reset sources and pin circuitry around the controller
// Assumes: one fault at a time, held 80 cycles from start_i, except the watchdog, which is a one-cycle pulse
// Notes: kinds 1 pin, 2 clock stuck, 3 comparator low, 4 watchdog, 5 supply drop, 6 level trip
`timescale 1ns/1ps
module rsc_source_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [2:0] kind_i,
	input wire logic pin_oe_i,
	input wire logic pin_drv_i,
	output logic pin_o,
	output logic level_low_o,
	output logic above_o,
	output logic comp_above_o,
	output logic mon_clk_o,
	output logic wdt_timeout_o
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] kind_q = 3'h0;
	logic tog_q = 1'b0;
	logic wdt_q = 1'b0;
	wire logic act = left_q != 8'h00;
	always_ff @(posedge clk_i) begin
		tog_q <= ~tog_q;
		wdt_q <= start_i && kind_i == 3'h4;
		if (start_i) begin
			left_q <= 8'h50;
			kind_q <= kind_i;
		end else if (act) begin
			left_q <= left_q - 8'h01;
		end
	end
	// pull-up on the pin: low when either side pulls
	assign pin_o = (pin_oe_i ? pin_drv_i : 1'b1) && !(act && kind_q == 3'h1);
	assign level_low_o = act && kind_q == 3'h6;
	assign mon_clk_o = (act && kind_q == 3'h2) ? 1'b1 : tog_q;
	// comparator kept settled: low only when a scenario asks
	assign comp_above_o = ~(act && kind_q == 3'h3);
	assign above_o = ~(act && kind_q == 3'h5);
	assign wdt_timeout_o = wdt_q;
endmodule

// File: tb/rsc_reset_source_controller_tb.sv
// Purpose: self-checking bench of the reset source controller
// Assumes: one AHB-Lite master, one slave, model drives the reset sources
// Notes: detector timeout shortened to 50 cycles to keep the run short
`timescale 1ns/1ps
module rsc_reset_source_controller_tb;
	localparam logic [31:0] A_CAUSE = rsc_pkg::ADDR_CAUSE;
	localparam logic [31:0] A_MON = rsc_pkg::ADDR_MON;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready, pin, pin_oe, above, cmp_abv, mon_clk, wdt_to, tick, stall, sys_rst_n;
	logic hresp, pin_drv, lvl_low;
	logic [31:0] hrdata;
	logic freq = 1'b0, ferase = 1'b0, frd = 1'b0, fsec = 1'b0, fstart = 1'b0;
	logic [15:0] faddr = 16'h0000, fraddr = 16'h0000;
	logic [7:0] fwdata = 8'h00;
	logic [7:0] frdata;
	logic [2:0] fault = 3'h0;
	int mismatches = 0;
	int compares = 0;
	int n;
	int k;
	logic [31:0] rd;
	logic oe_seen;
	logic [2:0] f_kind[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	logic [7:0] f_wr[7] = '{8'h12, 8'h02, 8'h06, 8'h22, 8'h02, 8'h02, 8'h02};
	logic [7:0] f_exp[7] = '{8'h90, 8'h81, 8'h84, 8'hA0, 8'h88, 8'h82, 8'h82};
	logic [7:0] f_oe[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};

	rsc_reset_source_controller #(.MCD_TIMEOUT_CYCLES(50)) rsc_reset_source_controller_i (
		.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .RST_PIN_I(pin),
		.RST_PIN_O(pin_drv), .RST_PIN_OE_O(pin_oe), .SUPPLY_ABOVE_LOW_I(above),
		.SUPPLY_ABOVE_HIGH_I(above), .LEVEL_MON_LOW_I(lvl_low), .COMP_PLUS_ABOVE_I(cmp_abv),
		.MON_CLK_I(mon_clk), .WDT_TIMEOUT_I(wdt_to), .WDT_TICK_O(tick), .FLASH_REQ_I(freq),
		.FLASH_ERASE_I(ferase), .FLASH_ADDR_I(faddr), .FLASH_WDATA_I(fwdata),
		.FLASH_RD_I(frd), .FLASH_RADDR_I(fraddr), .FLASH_SECURE_I(fsec),
		.FLASH_RDATA_O(frdata), .CPU_STALL_O(stall), .SYS_RST_N_O(sys_rst_n));

	rsc_source_model rsc_source_model_i (.clk_i(clk), .start_i(fstart), .kind_i(fault),
		.pin_oe_i(pin_oe), .pin_drv_i(pin_drv), .pin_o(pin), .level_low_o(lvl_low),
		.above_o(above), .comp_above_o(cmp_abv),
		.mon_clk_o(mon_clk), .wdt_timeout_o(wdt_to));

	initial begin
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] w8(input logic [7:0] b);
		return {24'h00_0000, b};
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang(input string what);
		mismatches++;
		$display("Error %s expected completion seen timeout", what);
		end_of_test();
	endtask

	// ready sampled at the edge, before that edge's updates land
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= rsc_pkg::HSIZE_WORD;
		for (n = 0; n == 0 || hready !== 1'b1; n++) begin
			@(posedge clk);
			if (n > 50) hang("bus_address");
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		for (n = 0; n == 0 || hready !== 1'b1; n++) begin
			@(posedge clk);
			if (n > 50) hang("bus_data");
		end
		rd = hrdata;
	endtask

	task automatic rst_cycle();
		oe_seen = 1'b0;
		for (n = 0; sys_rst_n !== 1'b0; n++) begin
			@(posedge clk);
			if (n > 150) hang("reset_entry");
		end
		for (n = 0; sys_rst_n !== 1'b1; n++) begin
			oe_seen |= pin_oe && !pin;
			@(posedge clk);
			if (n > 2000) hang("reset_exit");
		end
	endtask

	task automatic fop(input logic er, input logic [15:0] a, input logic [7:0] d, input int exp);
		freq <= 1'b1;
		ferase <= er;
		faddr <= a;
		fwdata <= d;
		@(posedge clk);
		freq <= 1'b0;
		@(posedge clk);
		for (n = 0; stall === 1'b1 && n < 1000; n++) @(posedge clk);
		chk("stall_cycles", 32'(exp), 32'(n));
	endtask

	task automatic fread(input logic [15:0] a, input logic [7:0] exp);
		frd <= 1'b1;
		fraddr <= a;
		@(posedge clk);
		frd <= 1'b0;
		@(posedge clk);
		chk("flash_byte", w8(exp), w8(frdata));
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rst_cycle();
		bus(1'b0, A_CAUSE, 32'h0000_0000);
		chk("cause", 32'h0000_0082, rd);
		bus(1'b0, A_MON, 32'h0000_0000);
		chk("monitor", 32'h0000_00D0, rd);
		bus(1'b0, 32'h0000_0100, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		chk("hresp", 32'h0000_0000, 32'(hresp));
		k = 0;
		repeat (120) begin
			@(posedge clk);
			if (tick === 1'b1) k++;
		end
		chk("wdt_ticks", 32'h0000_000A, 32'(k));
		$display("test power_on done");
		// whole-value writes keep the monitor selected
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, A_CAUSE, w8(f_wr[i]));
			if (f_kind[i] != 3'h0) begin
				fault <= f_kind[i];
				fstart <= 1'b1;
				@(posedge clk);
				fstart <= 1'b0;
			end
			rst_cycle();
			chk("pin_drive", w8(f_oe[i]), w8({7'h00, oe_seen}));
			bus(1'b0, A_CAUSE, 32'h0000_0000);
			chk("cause", w8(f_exp[i]), rd);
			$display("test source %0d done", i);
		end
		bus(1'b1, A_MON, 32'h0000_00BF);
		bus(1'b0, A_MON, 32'h0000_0000);
		chk("monitor", 32'h0000_00F0, rd);
		fop(1'b1, 16'h0010, 8'h00, 400);
		fread(16'h0010, 8'hFF);
		fop(1'b0, 16'h0010, 8'h5A, 40);
		fop(1'b0, 16'h0010, 8'hF0, 40);
		fread(16'h0010, 8'h50);
		fop(1'b0, 16'h0400, 8'h00, 0);
		rst_cycle();
		bus(1'b0, A_CAUSE, 32'h0000_0000);
		chk("cause", 32'h0000_00C0, rd);
		// threshold is low again after that reset
		fop(1'b0, 16'h0010, 8'h00, 0);
		rst_cycle();
		bus(1'b0, A_CAUSE, 32'h0000_0000);
		chk("cause", 32'h0000_00C0, rd);
		fsec <= 1'b1;
		fread(16'h0010, 8'h50);
		fsec <= 1'b0;
		rst_cycle();
		bus(1'b0, A_CAUSE, 32'h0000_0000);
		chk("cause", 32'h0000_00C0, rd);
		$display("test flash done");
		bus(1'b1, A_MON, 32'h0000_0010);
		bus(1'b1, A_CAUSE, 32'h0000_0010);
		rst_cycle();
		bus(1'b0, A_MON, 32'h0000_0000);
		chk("monitor", 32'h0000_0050, rd);
		$display("test monitor_keep done");
		end_of_test();
	end
endmodule
